// [riscv_boot_pkg.sv]
// constants and types shared by the serial boot loader and its core
package riscv_boot_pkg;
  // ****************************************
  // serial command codes
  // ****************************************
  localparam logic [7:0] CMD_LANE0 = 8'hC0;
  localparam logic [7:0] CMD_LANE3 = 8'hC3;
  localparam logic [7:0] CMD_ADDR  = 8'hC4;
  localparam logic [7:0] CMD_WRITE = 8'hC5;
  localparam logic [7:0] CMD_ECHO  = 8'hC6;
  localparam logic [7:0] CMD_BOOT  = 8'hC7;
  localparam logic [4:0] CMD_GROUP = 5'h18;
  // ****************************************
  // link, buffer and memory sizes
  // ****************************************
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [2:0] CS_IDLE   = 3'h7;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam int IMEM_WORDS = 16;
  localparam int DMEM_WORDS = 8;
  localparam int REG_COUNT  = 32;
  localparam logic [2:0] STATUS_WORDS = 3'h3;
  localparam logic [2:0] DM_CYCLE = 3'h0;
  localparam logic [2:0] DM_LINK  = 3'h1;
  localparam logic [2:0] DM_INSTR = 3'h2;
  // ****************************************
  // core constants
  // ****************************************
  localparam logic [4:0]  PASS_REG   = 5'h0A;
  localparam logic [31:0] PASS_VALUE = 32'h0000002D;
  localparam logic [31:0] PC_STEP    = 32'h00000004;
  localparam logic [6:0] OP_LUI = 7'h37;
  localparam logic [6:0] OP_AUI = 7'h17;
  localparam logic [6:0] OP_JAL = 7'h6F;
  localparam logic [6:0] OP_JLR = 7'h67;
  localparam logic [6:0] OP_BR  = 7'h63;
  localparam logic [6:0] OP_LD  = 7'h03;
  localparam logic [6:0] OP_ST  = 7'h23;
  localparam logic [6:0] OP_IMM = 7'h13;
  localparam logic [6:0] OP_REG = 7'h33;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    ST_FETCH = 5'b00001, ST_DECODE = 5'b00010, ST_EXEC = 5'b00100,
    ST_MEM = 5'b01000, ST_WB = 5'b10000
  } stage_t;
  typedef struct packed {
    logic [22:0] unused;
    logic        valid;
    logic [7:0]  data;
  } linkStatus_t;
  typedef struct packed {
    logic       failed;
    logic       passed;
    logic       cmdError;
    logic       mode;
    logic       miso;
    logic [2:0] unused;
  } dedOut_t;
endpackage : riscv_boot_pkg

// [spi_boot_core.sv]
// serial boot loader, echo link and staged integer core
//
// Function
// - reset enters boot mode, core held
// - each command is command then data byte
// - C0..C3 load buffer byte lanes 0..3
// - C4 captures 3-bit instruction address
// - C5 writes buffer to instruction memory
// - C5 copies written word to status word
// - C6 enters echo mode, releases core
// - echo mode returns every received byte
// - C7 returns to boot, restarts core at pc 0
// - unknown command in boot mode sets sticky error
// - mode pin low boot, high echo
// - three status words, first cycle counter
// - second word: last byte, valid bit
// - pass when register 10 equals 45
// - five stages, result after five cycles
// - 16 instruction words, 8 data words
// - no csr, fence, thread, privilege support
`timescale 1ns/1ps
module spi_boot_core (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // serial link pins
  input  wire logic                sclk,
  input  wire logic                csN,
  input  wire logic                mosi,
  // dedicated output pins
  output riscv_boot_pkg::dedOut_t  dedicatedOutputs
);
  import riscv_boot_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sclkS, csS, mosiS;      // three-stage chains
  logic       sclkF, csF, mosiF;      // filtered levels
  logic       next_sclkF, next_csF, next_mosiF;
  logic       sclkRise, sclkFall, csFall, active;

  // level changes only once stages two and three agree
  always_comb
  begin
    next_sclkF = (sclkS[1] == sclkS[2]) ? sclkS[2] : sclkF;
    next_csF   = (csS[1] == csS[2]) ? csS[2] : csF;
    next_mosiF = (mosiS[1] == mosiS[2]) ? mosiS[2] : mosiF;
    sclkRise   = next_sclkF & ~sclkF;
    sclkFall   = ~next_sclkF & sclkF;
    csFall     = csF & ~next_csF;
    active     = ~next_csF;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sclkS <= '0;
      csS   <= CS_IDLE;
      mosiS <= '0;
      sclkF <= 1'h0;
      csF   <= 1'h1;
      mosiF <= 1'h0;
    end
    else
    begin
      sclkS <= {sclkS[1:0], sclk};
      csS   <= {csS[1:0], csN};
      mosiS <= {mosiS[1:0], mosi};
      sclkF <= next_sclkF;
      csF   <= next_csF;
      mosiF <= next_mosiF;
    end
  end

  // ****************************************
  // link shifters
  // ****************************************
  logic [2:0] bitCnt, next_bitCnt;    // bit within byte
  logic [7:0] shRx, next_shRx;        // receive shifter
  logic [7:0] shTx, next_shTx;        // transmit shifter
  logic       byteDone, txLoad;
  logic [7:0] txHold;                 // byte waiting to go out
  logic       txPend;

  always_comb
  begin
    next_bitCnt = bitCnt;
    next_shRx   = shRx;
    next_shTx   = shTx;
    byteDone    = 1'b0;
    txLoad      = 1'b0;
    if (!active)
      next_bitCnt = '0;
    else if (sclkRise)
    begin
      next_shRx   = {shRx[6:0], next_mosiF};
      next_bitCnt = bitCnt + 3'h1;
      byteDone    = (bitCnt == LAST_BIT);
    end
    else if (sclkFall && bitCnt != '0)
      next_shTx = {shTx[6:0], 1'b0};
    // echo byte goes out in the next frame
    if (csFall || byteDone)
    begin
      txLoad    = 1'b1;
      next_shTx = txPend ? txHold : '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bitCnt <= '0;
      shRx   <= '0;
      shTx   <= '0;
    end
    else
    begin
      bitCnt <= next_bitCnt;
      shRx   <= next_shRx;
      shTx   <= next_shTx;
    end
  end

  // ****************************************
  // two-entry receive buffer
  // ****************************************
  logic [7:0] fifo [2];               // byte slots
  logic       wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [1:0] count, next_count;
  logic       push, pushReady, popValid, popReady, take;
  logic [7:0] head;
  logic       mode;

  // in echo mode, draining stalls while an echo byte is still unsent
  always_comb
  begin
    pushReady  = (count != BUF_DEPTH);
    push       = byteDone & pushReady;
    popValid   = (count != '0);
    popReady   = ~(mode & txPend);
    take       = popValid & popReady;
    head       = fifo[rdPtr];
    next_wrPtr = wrPtr ^ push;
    next_rdPtr = rdPtr ^ take;
    next_count = count + {1'b0, push} - {1'b0, take};
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      fifo[wrPtr] <= next_shRx;
    if (!rst_n)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // ****************************************
  // command interpreter
  // ****************************************
  logic        phase, next_phase;     // 1: data byte expected
  logic [7:0]  cmdReg, next_cmdReg;
  logic        next_mode, cmdError, next_cmdError;
  logic [31:0] instrBuf, next_instrBuf;
  logic [2:0]  imemAddr, next_imemAddr;
  logic [31:0] lastInstr, next_lastInstr;
  logic [7:0]  next_txHold, lastByte, next_lastByte;
  logic        next_txPend, rxValid, next_rxValid, rxClear, imemWe;

  always_comb
  begin
    next_phase = phase;
    next_cmdReg = cmdReg;
    next_mode = mode;
    next_cmdError = cmdError;
    next_instrBuf = instrBuf;
    next_imemAddr = imemAddr;
    next_lastInstr = lastInstr;
    next_txHold = txHold;
    next_lastByte = lastByte;
    next_rxValid = rxValid & ~rxClear;
    next_txPend = txPend & ~txLoad;
    imemWe = 1'b0;
    if (take)
    begin
      // new byte wins over a read clear
      next_lastByte = head;
      next_rxValid = 1'b1;
      if (mode)
      begin
        next_txHold = head;
        next_txPend = 1'b1;
        // only the return code is decoded
        if (!phase)
        begin
          next_cmdReg = head;
          next_phase = (head == CMD_BOOT);
        end
        else
        begin
          // back to boot after the data byte
          next_phase = 1'b0;
          next_mode = 1'b0;
        end
      end
      else if (!phase)
      begin
        next_cmdReg = head;
        next_phase = 1'b1;
        if (head[7:3] != CMD_GROUP)
          next_cmdError = 1'b1;
      end
      else
      begin
        next_phase = 1'b0;
        if (cmdReg[7:2] == CMD_LANE0[7:2])
          next_instrBuf[{cmdReg[1:0], 3'h0} +: 8] = head;
        case (cmdReg)
          CMD_ADDR: next_imemAddr = head[2:0];
          CMD_WRITE:
          begin
            imemWe = 1'b1;
            next_lastInstr = instrBuf;
          end
          CMD_ECHO: next_mode = 1'b1;
          default: next_phase = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      phase <= 1'b0;
      cmdReg <= '0;
      mode <= 1'b0;
      cmdError <= 1'b0;
      instrBuf <= '0;
      imemAddr <= '0;
      lastInstr <= '0;
      txHold <= '0;
      txPend <= 1'b0;
      lastByte <= '0;
      rxValid <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      cmdReg <= next_cmdReg;
      mode <= next_mode;
      cmdError <= next_cmdError;
      instrBuf <= next_instrBuf;
      imemAddr <= next_imemAddr;
      lastInstr <= next_lastInstr;
      txHold <= next_txHold;
      txPend <= next_txPend;
      lastByte <= next_lastByte;
      rxValid <= next_rxValid;
    end
  end

  // ****************************************
  // staged core
  // ****************************************
  // memory sizes
  logic [31:0] imem [IMEM_WORDS];
  logic [31:0] dmem [DMEM_WORDS];
  logic [31:0] regs [REG_COUNT];
  stage_t      stage, next_stage;
  logic [31:0] pc, ir, opA, opB, res, npc, cycleCnt;
  logic [31:0] next_pc, next_ir, next_opA, next_opB, next_res, next_npc;
  logic [31:0] immI, immS, immB, immU, immJ, aluB;
  logic [6:0]  op;
  logic [2:0]  f3;
  logic        alt, taken, regWe, dmemWe, passed, failed;
  linkStatus_t linkWord;

  always_comb
  begin
    op = ir[6:0];
    f3 = ir[14:12];
    immI = {{20{ir[31]}}, ir[31:20]};
    immS = {{20{ir[31]}}, ir[31:25], ir[11:7]};
    immB = {{19{ir[31]}}, ir[31], ir[7], ir[30:25], ir[11:8], 1'b0};
    immU = {ir[31:12], 12'h000};
    immJ = {{11{ir[31]}}, ir[31], ir[19:12], ir[20], ir[30:21], 1'b0};
    aluB = (op == OP_REG) ? opB : immI;
    alt = ir[30] & (op == OP_REG || f3 == 3'h5);
    taken = (f3[2] ? (f3[1] ? opA < opB : $signed(opA) < $signed(opB))
                   : opA == opB) ^ f3[0];
    linkWord = '{unused: '0, valid: rxValid, data: lastByte};
    next_stage = stage;
    next_pc = pc;
    next_ir = ir;
    next_opA = opA;
    next_opB = opB;
    next_res = res;
    next_npc = npc;
    regWe = 1'b0;
    dmemWe = 1'b0;
    rxClear = 1'b0;
    // core held while in boot mode
    if (!mode)
    begin
      next_stage = ST_FETCH;
      next_pc = '0;
    end
    else
      // one stage per cycle, write-back in the fifth
      unique case (stage)
        ST_FETCH:
        begin
          next_ir = imem[pc[5:2]];
          next_stage = ST_DECODE;
        end
        ST_DECODE:
        begin
          next_opA = regs[ir[19:15]];
          next_opB = regs[ir[24:20]];
          next_stage = ST_EXEC;
        end
        ST_EXEC:
        begin
          next_npc = pc + PC_STEP;
          unique case (f3)
            3'h0: next_res = alt ? opA - aluB : opA + aluB;
            3'h1: next_res = opA << aluB[4:0];
            3'h2: next_res = {31'h0, $signed(opA) < $signed(aluB)};
            3'h3: next_res = {31'h0, opA < aluB};
            3'h4: next_res = opA ^ aluB;
            3'h5: next_res = alt ? $signed(opA) >>> aluB[4:0] : opA >> aluB[4:0];
            3'h6: next_res = opA | aluB;
            3'h7: next_res = opA & aluB;
          endcase
          // system and fence codes fall to the default
          case (op)
            OP_LUI: next_res = immU;
            OP_AUI: next_res = pc + immU;
            OP_JAL:
            begin
              next_res = pc + PC_STEP;
              next_npc = pc + immJ;
            end
            OP_JLR:
            begin
              next_res = pc + PC_STEP;
              next_npc = (opA + immI) & ~32'h00000001;
            end
            OP_BR: next_npc = taken ? pc + immB : pc + PC_STEP;
            OP_LD: next_res = opA + immI;
            OP_ST: next_res = opA + immS;
            default: next_npc = pc + PC_STEP;
          endcase
          next_stage = ST_MEM;
        end
        ST_MEM:
        begin
          // status words are read-only to the core
          if (op == OP_LD)
            unique case (res[4:2])
              DM_CYCLE: next_res = cycleCnt;
              DM_LINK:
              begin
                next_res = linkWord;
                rxClear = 1'b1;
              end
              DM_INSTR: next_res = lastInstr;
              default: next_res = dmem[res[4:2]];
            endcase
          dmemWe = (op == OP_ST) && (res[4:2] >= STATUS_WORDS);
          next_stage = ST_WB;
        end
        ST_WB:
        begin
          regWe = (op != OP_BR) && (op != OP_ST) && (ir[11:7] != '0);
          next_pc = npc;
          next_stage = ST_FETCH;
        end
      endcase
  end

  always_ff @(posedge mclk)
  begin
    if (imemWe)
      imem[{1'b0, imemAddr}] <= instrBuf;
    if (dmemWe)
      dmem[res[4:2]] <= opB;
    if (!rst_n)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs[i] <= '0;
      stage <= ST_FETCH;
      {pc, ir, opA, opB, res, npc, cycleCnt} <= '0;
      passed <= 1'b0;
      failed <= 1'b1;
    end
    else
    begin
      if (regWe)
        regs[ir[11:7]] <= res;
      stage <= next_stage;
      pc <= next_pc;
      ir <= next_ir;
      opA <= next_opA;
      opB <= next_opB;
      res <= next_res;
      npc <= next_npc;
      cycleCnt <= cycleCnt + 32'h00000001;
      passed <= (regs[PASS_REG] == PASS_VALUE);
      failed <= (regs[PASS_REG] != PASS_VALUE);
    end
  end

  assign dedicatedOutputs = '{failed: failed, passed: passed, cmdError: cmdError,
                              mode: mode, miso: shTx[7], unused: '0};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic bootExec;
  assign bootExec = take & ~mode & phase;

  boot_after_reset_a: assert property ($rose(rst_n) |-> !mode && stage == ST_FETCH)
    else $error("not in boot after reset");
  lane_load_a: assert property (bootExec && cmdReg[7:2] == CMD_LANE0[7:2]
    |=> instrBuf[{$past(cmdReg[1:0]), 3'h0} +: 8] == $past(head)) else $error("lane not loaded");
  addr_load_a: assert property (bootExec && cmdReg == CMD_ADDR |=> imemAddr == $past(head[2:0]))
    else $error("address not captured");
  imem_write_a: assert property (bootExec && cmdReg == CMD_WRITE
    |=> imem[{1'b0, $past(imemAddr)}] == $past(instrBuf)) else $error("word not written");
  mirror_word_a: assert property (bootExec && cmdReg == CMD_WRITE |=> lastInstr == $past(instrBuf))
    else $error("status word not updated");
  echo_enter_a: assert property (bootExec && cmdReg == CMD_ECHO |=> mode ##1 stage == ST_DECODE)
    else $error("echo mode not entered");
  echo_back_a: assert property (take && mode |=> txPend && txHold == $past(head))
    else $error("byte not echoed");
  boot_return_a: assert property (take && mode && phase |=> !mode ##1 stage == ST_FETCH && pc == '0)
    else $error("boot not re-entered");
  error_sticky_a: assert property (cmdError |=> cmdError)
    else $error("error flag dropped");
  // a return to boot in mid-instruction restarts the core, so only a run with mode held counts
  wb_latency_a: assert property (stage == ST_FETCH && mode ##1 mode [*3] |=> stage == ST_WB)
    else $error("write-back not in fifth cycle");
  // the count restarts from zero on reset, so the first cycle after release is skipped
  counter_run_a: assert property ($past(rst_n) |-> cycleCnt == $past(cycleCnt) + 32'h00000001)
    else $error("cycle counter stalled");
  link_status_a: assert property (take |=> rxValid && lastByte == $past(head))
    else $error("link status not updated");
  pass_check_a: assert property ($past(rst_n)
    |-> passed == ($past(regs[PASS_REG]) == PASS_VALUE) && failed == !passed)
    else $error("pass flags wrong");
  echo_seen_c: cover property (bootExec && cmdReg == CMD_ECHO);
  error_seen_c: cover property ($rose(cmdError));
  buffer_full_c: cover property (count == BUF_DEPTH);
  pass_seen_c: cover property ($rose(passed));
endmodule : spi_boot_core

// [spi_boot_core_tb_top.sv]
// self-checking bench for the serial boot loader and its core
`timescale 1ns/1ps
module spi_boot_core_tb_top;
  import riscv_boot_pkg::*;
  // compare one value and count it
  `define CHECK(what, exp, got) \
    begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
        mismatches++; \
        $display("Error %s expected %0h seen %0h", what, exp, got); \
      end \
    end
  // ****************************************
  // signals
  // ****************************************
  localparam int LIMIT = 20000;   // cycle ceiling for the whole run
  logic       mclk;               // system clock
  logic       rst_n;              // synchronous reset
  logic       sclk;               // link clock from host
  logic       csN;                // link select from host
  logic       mosi;               // link data from host
  dedOut_t    dedicatedOutputs;   // device output pins
  int         mismatches;         // failed comparisons
  int         tests_run;          // all comparisons
  int         cycles = 0;         // timeout counter
  logic [7:0] rx;                 // byte returned by the host
  logic [7:0] prev;               // byte sent in the previous frame
  logic [7:0] b;                  // scratch byte

  // device and host
  spi_boot_core spi_boot_core_inst (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .sclk             (sclk),
    .csN              (csN),
    .mosi             (mosi),
    .dedicatedOutputs (dedicatedOutputs)
  );
  spi_host_model spi_host_model_inst (
    .mclk (mclk),
    .sclk (sclk),
    .csN  (csN),
    .mosi (mosi),
    .miso (dedicatedOutputs.miso)
  );

  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  // verdict and end of run
  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // reset for five cycles, then check the idle pins
  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    `CHECK("reset pins", 8'h80, dedicatedOutputs)
  endtask : do_reset

  // command byte then data byte
  task automatic send_pair(input logic [7:0] cmd, input logic [7:0] data);
    spi_host_model_inst.xfer(cmd, rx);
    spi_host_model_inst.xfer(data, rx);
    repeat (4) @(posedge mclk);
    // look at the pins away from the launching edge
    @(negedge mclk);
  endtask : send_pair

  // lanes in either order, address with random upper bits, then write
  task automatic write_word(input logic [2:0] addr, input logic [31:0] w, input bit down);
    int l;
    for (int j = 0; j < 4; j++)
    begin
      l = down ? 3 - j : j;
      send_pair(CMD_LANE0 + 8'(l), w[8*l +: 8]);
    end
    b = 8'($urandom);
    send_pair(CMD_ADDR, {b[7:3], addr});
    send_pair(CMD_WRITE, 8'($urandom));
  endtask : write_word

  // bounded wait for the pass flag, then both result pins
  task automatic wait_result(input logic want);
    int n;
    n = 0;
    while (dedicatedOutputs.passed !== want && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    @(negedge mclk);
    `CHECK("passed", want, dedicatedOutputs.passed)
    `CHECK("failed", ~want, dedicatedOutputs.failed)
  endtask : wait_result

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    mismatches = 0;
    tests_run = 0;
    b = 8'($urandom(32'h85854FF6));
    do_reset();
    spi_host_model_inst.cs_toggle();
    // return code in boot mode changes nothing
    send_pair(CMD_BOOT, 8'($urandom));
    `CHECK("mode", 1'b0, dedicatedOutputs.mode)
    `CHECK("cmdError", 1'b0, dedicatedOutputs.cmdError)
    // loop at word 1, load of status word 2 at word 0, marker 45 last
    write_word(3'h1, 32'h0000006F, 1'b0);
    write_word(3'h0, 32'h00802503, 1'b1);
    write_word(3'h2, 32'h0000002D, 1'b0);
    `CHECK("mode", 1'b0, dedicatedOutputs.mode)
    `CHECK("passed", 1'b0, dedicatedOutputs.passed)
    send_pair(CMD_ECHO, 8'($urandom));
    `CHECK("mode", 1'b1, dedicatedOutputs.mode)
    wait_result(1'b1);
    // echo frames: each byte returns one frame later
    prev = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      b = (k == 0) ? 8'hC8 : (k == 1) ? CMD_ECHO : 8'($urandom);
      if (b == CMD_BOOT)
        b = 8'h3C;
      spi_host_model_inst.xfer(b, rx);
      if (k > 0)
        `CHECK("echo", prev, rx)
      prev = b;
    end
    @(negedge mclk);
    `CHECK("cmdError", 1'b0, dedicatedOutputs.cmdError)
    `CHECK("mode", 1'b1, dedicatedOutputs.mode)
    // return code in echo mode, still echoed, then its data byte
    spi_host_model_inst.xfer(CMD_BOOT, rx);
    `CHECK("echo", prev, rx)
    spi_host_model_inst.xfer(8'($urandom), rx);
    `CHECK("echo", CMD_BOOT, rx)
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    `CHECK("mode", 1'b0, dedicatedOutputs.mode)
    // new word 0 gives 44: fail result
    write_word(3'h0, 32'h02C00513, 1'b1);
    send_pair(CMD_ECHO, 8'($urandom));
    `CHECK("mode", 1'b1, dedicatedOutputs.mode)
    wait_result(1'b0);
    send_pair(CMD_BOOT, 8'($urandom));
    `CHECK("mode", 1'b0, dedicatedOutputs.mode)
    // unknown code above the range, then known lane code C3 while the error stays set
    send_pair(8'hC8, 8'($urandom));
    `CHECK("cmdError", 1'b1, dedicatedOutputs.cmdError)
    send_pair(CMD_LANE3, 8'($urandom));
    `CHECK("cmdError", 1'b1, dedicatedOutputs.cmdError)
    // reset in mid-run clears the sticky error, then a code below the range sets it again
    do_reset();
    spi_host_model_inst.cs_toggle();
    send_pair(8'($urandom_range(0, 191)), 8'($urandom));
    `CHECK("cmdError", 1'b1, dedicatedOutputs.cmdError)
    `CHECK("mode", 1'b0, dedicatedOutputs.mode)
    do_reset();
    finish_test();
  end
endmodule : spi_boot_core_tb_top

// [spi_host_model.sv]
// serial host model that frames bytes for the boot loader link
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic mclk,
  // serial link pins
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  // ****************************************
  // link timing
  // ****************************************
  // half period of the link clock in mclk cycles (200 ns period)
  localparam int HALF = 4;

  // idle levels at time zero: clock low, not selected
  initial
  begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // ****************************************
  // host tasks
  // ****************************************
  // select toggled once
  task automatic cs_toggle();
    @(posedge mclk);
    csN <= 1'b1;
    repeat (8) @(posedge mclk);
    csN <= 1'b0;
    repeat (8) @(posedge mclk);
    csN <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : cs_toggle

  // one framed byte; the reply bit is taken late in the high phase,
  // where a mode 0 device must still hold it
  // mode 0, msb first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge mclk);
    csN  <= 1'b0;
    mosi <= tx[7];
    repeat (HALF - 1) @(posedge mclk);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge mclk);
      sclk <= 1'b1;
      repeat (HALF - 1) @(posedge mclk);
      @(negedge mclk);
      rx[i] = miso;
      @(posedge mclk);
      sclk <= 1'b0;
      // next bit goes out while the clock is low
      if (i > 0)
        mosi <= tx[i-1];
      repeat (HALF - 1) @(posedge mclk);
    end
    @(posedge mclk);
    // released data line shows the inverse, not the last bit
    csN  <= 1'b1;
    mosi <= ~tx[0];
    repeat (12) @(posedge mclk);
  endtask : xfer
endmodule : spi_host_model
